// ### hw/fpx_pkg.sv
// shared constants and carrier types for the numeric exception block
package fpx_pkg;

  // =====================================================================
  // register map (byte addresses on the register bus)
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;

  // control word fields
  localparam int CTL_INVALID_MASK  = 0;
  localparam int CTL_DIVIDE_MASK   = 2;
  localparam int CTL_OVERFLOW_MASK = 3;
  localparam int CTL_UNDERFLOW_MASK= 4;
  localparam int CTL_INEXACT_MASK  = 5;
  localparam int CTL_RC_LO         = 10;
  localparam logic [15:0] CTRL_RST = 16'h003F;

  // status word fields
  localparam int ST_INVALID   = 0;
  localparam int ST_DIVIDE    = 2;
  localparam int ST_OVERFLOW  = 3;
  localparam int ST_UNDERFLOW = 4;
  localparam int ST_INEXACT   = 5;
  localparam int ST_SUMMARY   = 7;
  localparam int ST_ROUND_UP  = 9;
  localparam logic [15:0] STATUS_RST = 16'h0000;

  // =====================================================================
  // exponent arithmetic
  localparam int EXP_W = 18;
  localparam logic signed [EXP_W-1:0] EXP_BIAS   = 18'sd24576;
  localparam logic signed [EXP_W-1:0] EXT_EMAX   = 18'sd16383;
  localparam logic signed [EXP_W-1:0] EXT_EMIN   = -18'sd16382;
  localparam logic signed [EXP_W-1:0] DBL_EMAX   = 18'sd1023;
  localparam logic signed [EXP_W-1:0] DBL_EMIN   = -18'sd1022;
  localparam logic signed [EXP_W-1:0] SGL_EMAX   = 18'sd127;
  localparam logic signed [EXP_W-1:0] SGL_EMIN   = -18'sd126;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // =====================================================================
  // enumerations
  typedef enum logic [2:0] {
    OP_ARITH       = 3'h0,
    OP_DIVIDE      = 3'h1,
    OP_LOG2_MUL    = 3'h2,
    OP_EXP_EXTRACT = 3'h3,
    OP_SCALE       = 3'h4,
    OP_STORE_REAL  = 3'h5,
    OP_STORE_INT   = 3'h6
  } op_t;

  typedef enum logic [1:0] {
    FMT_EXT    = 2'h0,
    FMT_DOUBLE = 2'h1,
    FMT_SINGLE = 2'h2
  } fmt_t;

  typedef enum logic [1:0] {
    RC_NEAREST = 2'h0,
    RC_DOWN    = 2'h1,
    RC_UP      = 2'h2,
    RC_CHOP    = 2'h3
  } rc_t;

  typedef enum logic [2:0] {
    RES_NORMAL  = 3'h0,
    RES_INF     = 3'h1,
    RES_ZERO    = 3'h2,
    RES_MAXFIN  = 3'h3,
    RES_BIASED  = 3'h4
  } res_kind_t;

  // =====================================================================
  // request from the pipeline and answer to it
  typedef struct packed {
    logic                    valid;
    op_t                     op;
    fmt_t                    fmt;
    logic                    dest_mem;
    logic                    sign_a;
    logic                    sign_b;
    logic                    a_zero;
    logic                    a_finite;
    logic                    b_zero;
    logic                    int_range_err;
    logic signed [EXP_W-1:0] exp;
    logic                    inexact;
    logic                    rounded_up;
  } req_t;

  typedef struct packed {
    logic                    valid;
    logic                    write_head;
    logic                    write_second;
    res_kind_t               kind;
    logic                    sign;
    logic signed [EXP_W-1:0] exp;
    logic                    round_up;
    logic                    invalid;
    logic                    handler;
  } resp_t;

endpackage

// ### hw/fpx_numeric_exc.sv
// numeric exception detection, default results and flag registers
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
// =======================================================================
// How it works
// RULE1 - nonzero finite divided by zero raises divide fault
// RULE2 - divide flag and mask at bit 2
// RULE3 - divides, log-multiply and extract report divide fault
// RULE4 - masked divide fault writes signed default result
// RULE5 - unmasked divide fault requests handler, writes nothing
// RULE6 - overflow when result exceeds destination largest finite
// RULE7 - integer stores never overflow, signal invalid instead
// RULE8 - overflow flag and mask at bit 3
// RULE9 - masked overflow default depends on rounding control
// RULE10 - unmasked overflow to memory leaves everything unchanged; the code still sets the overflow and summary flags and clears round-up
// RULE11 - unmasked overflow to register divides exponent by bias
// RULE12 - scale overflowing again stores signed infinity
// RULE13 - underflow when result below smallest normalized value
// RULE14 - underflow flag and mask at bit 4
// RULE15 - unmasked underflow to memory stores nothing
// RULE16 - unmasked underflow to register multiplies exponent by bias
// RULE17 - scale underflowing again stores signed zero
// RULE18 - inexact flag and mask at bit 5
// RULE19 - plain inexact sets round-up, handler if unmasked
// RULE20 - inexact with masked over/underflow sets both flags
// RULE21 - inexact with unmasked register case sets both flags
// RULE22 - unmasked memory case hides inexact, clears round-up
// RULE23 - unmasked exception also sets error summary flag
// RULE24 - handler request held until summary flag cleared
module fpx_numeric_exc
(
  // clock, reset, enable
  input  wire logic                i_clk,
  input  wire logic                i_srst,
  input  wire logic                i_ce,
  // initialisation from the pipeline
  input  wire logic                i_init,
  // operation from the pipeline, answer one cycle later
  input  wire fpx_pkg::req_t       i_req,
  output      fpx_pkg::resp_t      o_resp,
  output      logic                o_handler_req,
  // axi4-lite slave
  input  wire logic [11:0]         i_awaddr,
  input  wire logic                i_awvalid,
  output      logic                o_awready,
  input  wire logic [31:0]         i_wdata,
  input  wire logic [3:0]          i_wstrb,
  input  wire logic                i_wvalid,
  output      logic                o_wready,
  output      logic [1:0]          o_bresp,
  output      logic                o_bvalid,
  input  wire logic                i_bready,
  input  wire logic [11:0]         i_araddr,
  input  wire logic                i_arvalid,
  output      logic                o_arready,
  output      logic [31:0]         o_rdata,
  output      logic [1:0]          o_rresp,
  output      logic                o_rvalid,
  input  wire logic                i_rready
);

  // =====================================================================
  // helpers
  // 0 = control, 1 = status, 2 = unmapped
  function automatic logic [1:0] reg_sel(input logic [11:0] addr);
    if (addr == fpx_pkg::CTRL_ADDR)
      return 2'h0;
    else if (addr == fpx_pkg::STATUS_ADDR)
      return 2'h1;
    else
      return 2'h2;
  endfunction

  function automatic logic signed [fpx_pkg::EXP_W-1:0] emax_of(
    input fpx_pkg::fmt_t fmt);
    case (fmt)
      fpx_pkg::FMT_DOUBLE: return fpx_pkg::DBL_EMAX;
      fpx_pkg::FMT_SINGLE: return fpx_pkg::SGL_EMAX;
      default:             return fpx_pkg::EXT_EMAX;
    endcase
  endfunction

  function automatic logic signed [fpx_pkg::EXP_W-1:0] emin_of(
    input fpx_pkg::fmt_t fmt);
    case (fmt)
      fpx_pkg::FMT_DOUBLE: return fpx_pkg::DBL_EMIN;
      fpx_pkg::FMT_SINGLE: return fpx_pkg::SGL_EMIN;
      default:             return fpx_pkg::EXT_EMIN;
    endcase
  endfunction

  // =====================================================================
  // state
  logic [15:0]        ctrl_q,    ctrl_d;
  logic [15:0]        status_q,  status_d;
  fpx_pkg::resp_t     resp_q,    resp_d;
  logic               awready_q, awready_d;
  logic               wready_q,  wready_d;
  logic               bvalid_q,  bvalid_d;
  logic [1:0]         bresp_q,   bresp_d;
  logic               arready_q, arready_d;
  logic               rvalid_q,  rvalid_d;
  logic [31:0]        rdata_q,   rdata_d;
  logic [1:0]         rresp_q,   rresp_d;

  // =====================================================================
  // classification of the current request
  logic       m_inv, m_div, m_ovf, m_unf, m_inx;
  fpx_pkg::rc_t rc;
  logic       div_class, dz, int_store, real_chk;
  logic       ovf, unf, inx;
  logic signed [fpx_pkg::EXP_W-1:0] exp_dn, exp_up;
  logic [15:0] hw_set;
  logic        c1_wr, c1_val;

  always_comb
  begin
    m_inv = ctrl_q[fpx_pkg::CTL_INVALID_MASK];
    m_div = ctrl_q[fpx_pkg::CTL_DIVIDE_MASK];            // RULE2
    m_ovf = ctrl_q[fpx_pkg::CTL_OVERFLOW_MASK];          // RULE8
    m_unf = ctrl_q[fpx_pkg::CTL_UNDERFLOW_MASK];         // RULE14
    m_inx = ctrl_q[fpx_pkg::CTL_INEXACT_MASK];           // RULE18
    rc    = fpx_pkg::rc_t'(ctrl_q[fpx_pkg::CTL_RC_LO +: 2]);
    // internal divides of log-multiply and extract count too
    div_class = i_req.op == fpx_pkg::OP_DIVIDE ||
                i_req.op == fpx_pkg::OP_LOG2_MUL ||
                i_req.op == fpx_pkg::OP_EXP_EXTRACT;     // RULE3
    case (i_req.op)
      fpx_pkg::OP_DIVIDE:
        dz = i_req.b_zero && !i_req.a_zero && i_req.a_finite; // RULE1
      fpx_pkg::OP_LOG2_MUL:
        dz = i_req.a_zero && !i_req.b_zero;               // RULE1
      fpx_pkg::OP_EXP_EXTRACT:
        dz = i_req.a_zero;                                // RULE1
      default:
        dz = 1'b0;
    endcase
    dz        = dz && div_class && i_req.valid;
    int_store = i_req.valid && i_req.op == fpx_pkg::OP_STORE_INT;
    // integer stores never reach the real-range checks
    real_chk  = i_req.valid && !dz && !int_store;        // RULE7
    ovf = real_chk && (i_req.exp > emax_of(i_req.fmt));  // RULE6
    unf = real_chk && (i_req.exp < emin_of(i_req.fmt));  // RULE13
    inx = real_chk && i_req.inexact;                     // RULE18
    exp_dn = i_req.exp - fpx_pkg::EXP_BIAS;              // RULE11
    exp_up = i_req.exp + fpx_pkg::EXP_BIAS;              // RULE16
  end

  // =====================================================================
  // response and flag events
  always_comb
  begin
    resp_d        = '0;
    resp_d.valid  = i_req.valid;
    resp_d.exp    = i_req.exp;
    resp_d.sign   = i_req.sign_a;
    resp_d.kind   = fpx_pkg::RES_NORMAL;
    hw_set        = '0;
    c1_wr         = 1'b0;
    c1_val        = 1'b0;
    if (dz)
    begin
      hw_set[fpx_pkg::ST_DIVIDE] = 1'b1;                 // RULE2
      if (m_div)
      begin
        resp_d.write_head = 1'b1;                        // RULE4
        resp_d.kind       = fpx_pkg::RES_INF;
        case (i_req.op)
          fpx_pkg::OP_DIVIDE:
            resp_d.sign = i_req.sign_a ^ i_req.sign_b;   // RULE4
          fpx_pkg::OP_LOG2_MUL:
            resp_d.sign = !i_req.sign_b;                 // RULE4
          default:
          begin
            // extract: head gets signed zero, second gets -inf
            resp_d.kind         = fpx_pkg::RES_ZERO;     // RULE4
            resp_d.sign         = i_req.sign_a;
            resp_d.write_second = 1'b1;
          end
        endcase
      end
      else
        resp_d.handler = 1'b1;                           // RULE5
    end
    else if (int_store)
    begin
      if (i_req.int_range_err)
      begin
        hw_set[fpx_pkg::ST_INVALID] = 1'b1;              // RULE7
        resp_d.invalid    = 1'b1;
        resp_d.handler    = !m_inv;
        resp_d.write_head = m_inv;
      end
      else
        resp_d.write_head = 1'b1;
    end
    else if (i_req.valid)
    begin
      resp_d.write_head = 1'b1;
      c1_wr  = inx;
      c1_val = i_req.rounded_up;                         // RULE19
      if (ovf || unf)
      begin
        hw_set[fpx_pkg::ST_OVERFLOW]  = ovf;             // RULE8
        hw_set[fpx_pkg::ST_UNDERFLOW] = unf;             // RULE14
        if ((ovf && m_ovf) || (unf && m_unf))
        begin
          hw_set[fpx_pkg::ST_INEXACT] = inx;             // RULE20
          resp_d.handler = inx && !m_inx;                // RULE20
          if (ovf)
          begin
            // default result follows rounding direction
            case (rc)                                    // RULE9
              fpx_pkg::RC_NEAREST: resp_d.kind = fpx_pkg::RES_INF;
              fpx_pkg::RC_DOWN:
                resp_d.kind = i_req.sign_a ? fpx_pkg::RES_INF
                                           : fpx_pkg::RES_MAXFIN;
              fpx_pkg::RC_UP:
                resp_d.kind = i_req.sign_a ? fpx_pkg::RES_MAXFIN
                                           : fpx_pkg::RES_INF;
              default:             resp_d.kind = fpx_pkg::RES_MAXFIN;
            endcase
          end
        end
        else if (i_req.dest_mem)
        begin
          // nothing stored, inexact hidden, round-up cleared
          resp_d.write_head = 1'b0;                      // RULE10
          resp_d.handler    = 1'b1;                      // RULE15
          c1_wr             = 1'b1;                      // RULE22
          c1_val            = 1'b0;                      // RULE22
        end
        else
        begin
          hw_set[fpx_pkg::ST_INEXACT] = inx;             // RULE21
          resp_d.handler  = 1'b1;                        // RULE11
          resp_d.kind     = fpx_pkg::RES_BIASED;
          resp_d.exp      = ovf ? exp_dn : exp_up;       // RULE16
          c1_wr           = 1'b1;                        // RULE11
          if (i_req.op == fpx_pkg::OP_SCALE && ovf &&
              exp_dn > fpx_pkg::EXT_EMAX)
            resp_d.kind = fpx_pkg::RES_INF;              // RULE12
          else if (i_req.op == fpx_pkg::OP_SCALE && unf &&
                   exp_up < fpx_pkg::EXT_EMIN)
            resp_d.kind = fpx_pkg::RES_ZERO;             // RULE17
        end
      end
      else if (inx)
      begin
        hw_set[fpx_pkg::ST_INEXACT] = 1'b1;              // RULE19
        resp_d.handler = !m_inx;                         // RULE19
      end
    end
    resp_d.round_up = c1_wr ? c1_val : status_q[fpx_pkg::ST_ROUND_UP];
    hw_set[fpx_pkg::ST_SUMMARY] = resp_d.handler;        // RULE23
  end

  // =====================================================================
  // register bus and register file
  logic        wr_go, rd_go;
  logic [15:0] wmask, wclr;

  always_comb
  begin
    awready_d = !awready_q && !bvalid_q && i_awvalid && i_wvalid;
    wready_d  = awready_d;
    wr_go     = awready_q && wready_q;
    bvalid_d  = wr_go || (bvalid_q && !i_bready);
    bresp_d   = bresp_q;
    if (wr_go)
      bresp_d = reg_sel(i_awaddr) == 2'h2 ? fpx_pkg::AXI_SLVERR
                                          : fpx_pkg::AXI_OKAY;
    arready_d = !arready_q && !rvalid_q && i_arvalid;
    rd_go     = arready_q;
    rvalid_d  = rd_go || (rvalid_q && !i_rready);
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (rd_go)
    begin
      case (reg_sel(i_araddr))
        2'h0:    rdata_d = {16'h0000, ctrl_q};
        2'h1:    rdata_d = {16'h0000, status_q};
        default: rdata_d = 32'h0000_0000;
      endcase
      rresp_d = reg_sel(i_araddr) == 2'h2 ? fpx_pkg::AXI_SLVERR
                                          : fpx_pkg::AXI_OKAY;
    end
    wmask = {{8{i_wstrb[1]}}, {8{i_wstrb[0]}}};
    ctrl_d = ctrl_q;
    wclr   = '0;
    if (wr_go && reg_sel(i_awaddr) == 2'h0)
      ctrl_d = (ctrl_q & ~wmask) | (i_wdata[15:0] & wmask);
    if (wr_go && reg_sel(i_awaddr) == 2'h1)
      wclr = i_wdata[15:0] & wmask;
    // a flag raised in the clearing cycle survives the clear
    status_d = (status_q & ~wclr) | hw_set;              // RULE24
    status_d[fpx_pkg::ST_ROUND_UP] = resp_d.round_up &
      !(wclr[fpx_pkg::ST_ROUND_UP] && !c1_wr);
    if (i_init)
    begin
      ctrl_d   = fpx_pkg::CTRL_RST;
      status_d = fpx_pkg::STATUS_RST;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      ctrl_q    <= fpx_pkg::CTRL_RST;
      status_q  <= fpx_pkg::STATUS_RST;
      resp_q    <= '0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= 2'h0;
    end
    else if (i_ce)
    begin
      ctrl_q    <= ctrl_d;
      status_q  <= status_d;
      resp_q    <= resp_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign o_resp        = resp_q;
  // the summary flop itself drives dispatch so it holds until cleared
  assign o_handler_req = status_q[fpx_pkg::ST_SUMMARY];  // RULE24
  assign o_awready     = awready_q;
  assign o_wready      = wready_q;
  assign o_bvalid      = bvalid_q;
  assign o_bresp       = bresp_q;
  assign o_arready     = arready_q;
  assign o_rvalid      = rvalid_q;
  assign o_rdata       = rdata_q;
  assign o_rresp       = rresp_q;

  // =====================================================================
  // checks
  logic go;
  assign go = i_ce && !i_init;

  property p_dz_masked;
    @(posedge i_clk) disable iff (i_srst)
    (go && dz && m_div && i_req.op == fpx_pkg::OP_DIVIDE) |=>
      o_resp.kind == fpx_pkg::RES_INF && o_resp.write_head &&
      status_q[fpx_pkg::ST_DIVIDE] &&
      o_resp.sign == ($past(i_req.sign_a) ^ $past(i_req.sign_b));
  endproperty
  a_dz_masked: assert property (p_dz_masked) // RULE4
    else $error("masked divide fault default wrong");

  property p_dz_unmasked;
    @(posedge i_clk) disable iff (i_srst)
    (go && dz && !m_div) |=> !o_resp.write_head &&
      !o_resp.write_second && o_handler_req;
  endproperty
  a_dz_unmasked: assert property (p_dz_unmasked) // RULE5
    else $error("unmasked divide fault wrote result");

  property p_int_store;
    @(posedge i_clk) disable iff (i_srst)
    (go && int_store && wclr == '0) |=>
      $stable(status_q[fpx_pkg::ST_OVERFLOW +: 2]);
  endproperty
  a_int_store: assert property (p_int_store) // RULE7
    else $error("integer store raised overflow");

  property p_ovf_mem;
    @(posedge i_clk) disable iff (i_srst)
    (go && ovf && !m_ovf && i_req.dest_mem) |=>
      !o_resp.write_head && !o_resp.round_up && o_resp.handler;
  endproperty
  a_ovf_mem: assert property (p_ovf_mem) // RULE22
    else $error("unmasked memory overflow response wrong");

  property p_ovf_reg;
    @(posedge i_clk) disable iff (i_srst)
    (go && ovf && !m_ovf && !i_req.dest_mem &&
     i_req.op != fpx_pkg::OP_SCALE) |=>
      o_resp.exp == $past(i_req.exp) - 18'sd24576 &&
      o_resp.kind == fpx_pkg::RES_BIASED;
  endproperty
  a_ovf_reg: assert property (p_ovf_reg) // RULE11
    else $error("overflow bias not applied");

  property p_unf_reg;
    @(posedge i_clk) disable iff (i_srst)
    (go && unf && !m_unf && !i_req.dest_mem &&
     i_req.op != fpx_pkg::OP_SCALE) |=>
      o_resp.exp == $past(i_req.exp) + 18'sd24576 &&
      status_q[fpx_pkg::ST_UNDERFLOW];
  endproperty
  a_unf_reg: assert property (p_unf_reg) // RULE16
    else $error("underflow bias not applied");

  property p_inx_plain;
    @(posedge i_clk) disable iff (i_srst)
    (go && inx && !ovf && !unf) |=>
      o_resp.round_up == $past(i_req.rounded_up) &&
      o_resp.handler == !$past(m_inx);
  endproperty
  a_inx_plain: assert property (p_inx_plain) // RULE19
    else $error("plain inexact response wrong");

  property p_summary;
    @(posedge i_clk) disable iff (i_srst)
    (go && resp_d.handler) |=> o_handler_req ##1
      (o_handler_req || $past(wclr[fpx_pkg::ST_SUMMARY]) ||
       $past(i_init) || !$past(i_ce));
  endproperty
  a_summary: assert property (p_summary) // RULE23
    else $error("summary flag not raised or dropped");

endmodule

// ### tb/fpx_pipe_model.sv
// pipeline model that hands one operation to the block per fire pulse
`timescale 1ns/10ps
module fpx_pipe_model
(
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_srst,
  // operation to issue
  input  wire logic          i_fire,
  input  wire fpx_pkg::req_t i_next,
  // request towards the block
  output      fpx_pkg::req_t o_req
);
  // idle cycles scramble the payload so a stale operand never looks valid
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_req <= '0;
    else if (i_fire)
      o_req <= i_next;
    else
      o_req <= fpx_pkg::req_t'({1'h0, ~o_req[$bits(o_req)-2:0]});
  end
endmodule

// ### tb/fpu_numeric_exception_logic_tb_top.sv
// self-checking bench for the numeric exception block
`timescale 1ns/10ps
module fpu_numeric_exception_logic_tb_top;
  logic           i_clk = 1'h0;
  logic           i_srst = 1'h1;
  logic           init = 1'h0;
  logic           ce = 1'h1;
  logic           fire = 1'h0;
  fpx_pkg::req_t  r = '0;
  fpx_pkg::req_t  n = '0;
  fpx_pkg::req_t  req;
  fpx_pkg::resp_t rsp;
  logic           hreq, awr, wr, bv, arr, rv;
  logic [11:0]    awa = 12'h000, ara = 12'h000;
  logic [31:0]    wd = 32'h0, rd, got;
  logic           awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
  logic [1:0]     bresp, rresp, xr;
  logic [15:0]    seed = 16'h000E;
  int             failures = 0, total_checks = 0;

  fpx_pipe_model PIPE (.i_clk(i_clk), .i_srst(i_srst), .i_fire(fire),
                       .i_next(r), .o_req(req));
  fpx_numeric_exc DUT
  (
    .i_clk(i_clk), .i_srst(i_srst), .i_ce(ce), .i_init(init),
    .i_req(req), .o_resp(rsp), .o_handler_req(hreq),
    .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd),
    .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wr), .o_bresp(bresp),
    .o_bvalid(bv), .i_bready(br), .i_araddr(ara), .i_arvalid(arv),
    .o_arready(arr), .o_rdata(rd), .o_rresp(rresp), .o_rvalid(rv),
    .i_rready(rr)
  );

  always #20 i_clk = ~i_clk;

  // =====================================================================
  // checking and stimulus helpers
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [15:0] nx(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // signs and round direction are random, operand class is the caller's
  function automatic fpx_pkg::req_t mk(fpx_pkg::op_t o, fpx_pkg::fmt_t f,
                                       logic m, az, bz, ie, int e, logic x);
    seed = nx(seed);
    return '{1'h1, o, f, m, seed[0], seed[1], az, 1'h1, bz, ie, e[17:0], x,
             seed[2]};
  endfunction

  function automatic fpx_pkg::res_kind_t ovk(int c, logic s);
    return (c == 0 || (c == 1 && s) || (c == 2 && !s)) ? fpx_pkg::RES_INF
                                                       : fpx_pkg::RES_MAXFIN;
  endfunction

  task automatic axw(logic [11:0] a, logic [31:0] d);
    @(posedge i_clk);
    awa <= a;
    wd  <= d;
    awv <= 1'h1;
    wv  <= 1'h1;
    br  <= 1'h1;
    do @(posedge i_clk); while (!(awr && wr));
    awv <= 1'h0;
    wv  <= 1'h0;
    while (!bv) @(posedge i_clk);
    br <= 1'h0;
    xr = bresp;
  endtask

  task automatic axr(logic [11:0] a);
    @(posedge i_clk);
    ara <= a;
    arv <= 1'h1;
    rr  <= 1'h1;
    do @(posedge i_clk); while (!arr);
    arv <= 1'h0;
    while (!rv) @(posedge i_clk);
    rr <= 1'h0;
    got = rd;
    xr = rresp;
  endtask

  task automatic st(logic [31:0] e);
    axr(fpx_pkg::STATUS_ADDR);
    chk("status", got, e);
  endtask

  task automatic clr(logic [31:0] c);
    axw(fpx_pkg::CTRL_ADDR, c);
    axw(fpx_pkg::STATUS_ADDR, 32'h0000FFFF);
  endtask

  // the model launches one edge after fire, the answer one edge later
  task automatic go();
    @(posedge i_clk);
    r    <= n;
    fire <= 1'h1;
    @(posedge i_clk);
    fire <= 1'h0;
    @(posedge i_clk);
    #1;
    chk("resp valid", rsp.valid, 1'h1);
  endtask

  // =====================================================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_srst <= 1'h0;
    axr(fpx_pkg::CTRL_ADDR);
    chk("ctrl", got, 32'h3F);
    st(32'h0);
    axr(12'h008);
    chk("rresp", xr, fpx_pkg::AXI_SLVERR);
    axw(12'h008, 32'h0);
    chk("bresp", xr, fpx_pkg::AXI_SLVERR);
    for (int i = 1; i < 4; i++)
    begin
      clr(32'h3F);
      n = mk(fpx_pkg::op_t'(3'(i)), fpx_pkg::FMT_EXT, 0, i > 1, i == 1, 0, 0,
             0);
      go();
      chk("dz kind", rsp.kind, i == 3 ? fpx_pkg::RES_ZERO : fpx_pkg::RES_INF);
      chk("dz sign", rsp.sign, i == 1 ? n.sign_a ^ n.sign_b : i == 2 ?
          !n.sign_b : n.sign_a);
      chk("dz second", rsp.write_second, i == 3);
      st(32'h4);
    end
    clr(32'h3F);
    n = mk(fpx_pkg::OP_DIVIDE, fpx_pkg::FMT_EXT, 0, 1, 1, 0, 0, 0);
    go();
    axr(fpx_pkg::STATUS_ADDR);
    chk("zero by zero", got[2], 1'h0);
    clr(32'h3B);
    n = mk(fpx_pkg::OP_DIVIDE, fpx_pkg::FMT_EXT, 0, 0, 1, 0, 0, 0);
    go();
    chk("dz head", rsp.write_head, 1'h0);
    chk("dz handler", rsp.handler, 1'h1);
    repeat (4) @(posedge i_clk);
    chk("hreq held", hreq, 1'h1);
    st(32'h84);
    axw(fpx_pkg::STATUS_ADDR, 32'h80);
    @(posedge i_clk);
    #1;
    chk("hreq clear", hreq, 1'h0);
    // four rounding modes past the limit, then the largest legal exponent
    for (int c = 0; c < 5; c++)
    begin
      clr(32'h3F | ((c & 3) << 10));
      n = mk(fpx_pkg::OP_STORE_REAL, fpx_pkg::FMT_DOUBLE, 1, 0, 0, 0,
             1024 - c / 4, 0);
      go();
      chk("ovf kind", rsp.kind, c < 4 ? ovk(c, n.sign_a) : 3'h0);
      st(c < 4 ? 32'h8 : 32'h0);
    end
    clr(32'h3F);
    n = mk(fpx_pkg::OP_STORE_INT, fpx_pkg::FMT_DOUBLE, 1, 0, 0, 1, 2000, 0);
    go();
    chk("int invalid", rsp.invalid, 1'h1);
    st(32'h1);
    clr(32'h37);
    n = mk(fpx_pkg::OP_STORE_REAL, fpx_pkg::FMT_SINGLE, 1, 0, 0, 0, 128, 1);
    go();
    chk("mem head", rsp.write_head, 1'h0);
    chk("mem c1", rsp.round_up, 1'h0);
    st(32'h88);
    clr(32'h37);
    n = mk(fpx_pkg::OP_ARITH, fpx_pkg::FMT_EXT, 0, 0, 0, 0, 16384 + seed[7:0],
           1);
    go();
    chk("ovf biased", rsp.exp, n.exp - fpx_pkg::EXP_BIAS);
    chk("ovf c1", rsp.round_up, n.rounded_up);
    st(32'hA8 | (n.rounded_up << 9));
    n = mk(fpx_pkg::OP_SCALE, fpx_pkg::FMT_EXT, 0, 0, 0, 0, 41000, 0);
    go();
    chk("scale inf", {rsp.kind, rsp.sign}, {fpx_pkg::RES_INF, n.sign_a});
    clr(32'h2F);
    n = mk(fpx_pkg::OP_ARITH, fpx_pkg::FMT_EXT, 0, 0, 0, 0, -16383 - seed[7:0],
           0);
    go();
    chk("unf biased", rsp.exp, n.exp + fpx_pkg::EXP_BIAS);
    n = mk(fpx_pkg::OP_STORE_REAL, fpx_pkg::FMT_SINGLE, 1, 0, 0, 0, -127, 0);
    go();
    chk("unf head", {rsp.write_head, rsp.handler}, 2'h1);
    st(32'h90);
    n = mk(fpx_pkg::OP_SCALE, fpx_pkg::FMT_EXT, 0, 0, 0, 0, -41000, 0);
    go();
    chk("scale zero", {rsp.kind, rsp.sign}, {fpx_pkg::RES_ZERO, n.sign_a});
    clr(32'h3F);
    n = mk(fpx_pkg::OP_ARITH, fpx_pkg::FMT_EXT, 0, 0, 0, 0, 0, 1);
    go();
    chk("pe c1", {rsp.round_up, rsp.handler}, {n.rounded_up, 1'h0});
    st(32'h20 | (n.rounded_up << 9));
    clr(32'h1F);
    n = mk(fpx_pkg::OP_ARITH, fpx_pkg::FMT_EXT, 0, 0, 0, 0, 20000, 1);
    go();
    chk("pe ovf", {rsp.kind, rsp.handler}, {fpx_pkg::RES_INF, 1'h1});
    st(32'hA8 | (n.rounded_up << 9));
    @(posedge i_clk);
    init <= 1'h1;
    @(posedge i_clk);
    init <= 1'h0;
    axr(fpx_pkg::CTRL_ADDR);
    chk("init ctrl", got, 32'h3F);
    st(32'h0);
    // an operation that arrives while the enable is low must leave no trace
    n = mk(fpx_pkg::OP_DIVIDE, fpx_pkg::FMT_EXT, 0, 0, 1, 0, 0, 0);
    @(posedge i_clk);
    ce   <= 1'h0;
    r    <= n;
    fire <= 1'h1;
    @(posedge i_clk);
    fire <= 1'h0;
    @(posedge i_clk);
    ce <= 1'h1;
    chk("frozen resp", rsp.valid, 1'h0);
    st(32'h0);
    print_verdict();
  end

  // the whole sequence needs well under ten thousand cycles
  initial
  begin
    #2000000;
    failures++;
    print_verdict();
  end
endmodule
